// File: ldc_host_model.sv
// Bus master model standing in for the host processor
`timescale 1ns/1ns
`default_nettype none
module ldc_host_model #(
  parameter int Q = 6
) (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    wt(Q);
    sda_low <= !b;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    r = sda_line;
    scl <= 1'b0;
  endtask
  task automatic start;
    wt(Q);
    sda_low <= 1'b0;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    sda_low <= 1'b1;
    wt(Q);
    scl <= 1'b0;
  endtask
  task automatic stop;
    wt(Q);
    sda_low <= 1'b1;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    sda_low <= 1'b0;
    wt(Q);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    // Single byte answered with not-acknowledge
    bit_io(1'b1, r);
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra,
                    input logic [7:0] d, output logic ok);
    logic a1, a2, a3;
    start();
    send({dev, 1'b0}, a1);
    send(ra, a2);
    send(d, a3);
    stop();
    ok = a1 & a2 & a3;
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ra,
                    output logic [7:0] d, output logic ok);
    logic a1, a2, a3;
    start();
    send({dev, 1'b0}, a1);
    send(ra, a2);
    start();
    send({dev, 1'b1}, a3);
    recv(d);
    stop();
    ok = a1 & a2 & a3;
  endtask
endmodule
`default_nettype wire

// File: ldc_i2c_slave.sv
// Single-byte I2C slave byte engine
`timescale 1ns/1ns
`default_nettype none
module ldc_i2c_slave (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic [6:0] dev_addr,
  input wire logic disabled,
  input wire logic [7:0] rd_data,
  output logic sda_oe,
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_stb,
  output logic rd_stb
);
  typedef enum logic [3:0] {
    ldc_idle, ldc_addr, ldc_addr_ack, ldc_reg, ldc_reg_ack,
    ldc_wdata, ldc_wdata_ack, ldc_rdata, ldc_rdata_ack, ldc_ignore, ldc_skip
  } ldc_i2c_st_t;

  ldc_i2c_st_t st_ff;
  logic scl_d_ff, sda_d_ff, rw_ff, oe_ff, wr_ff, rd_ff;
  logic [7:0] sh_ff, reg_ff, wd_ff;
  logic [3:0] cnt_ff;
  logic scl_rise, scl_fall, start_c, stop_c;

  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_c = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_c = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign sda_oe = oe_ff;
  assign reg_addr = reg_ff;
  assign wr_data = wd_ff;
  assign wr_stb = wr_ff;
  assign rd_stb = rd_ff;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ldc_idle;
      oe_ff <= 1'b0;
      rw_ff <= 1'b0;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      reg_ff <= 8'h00;
      wd_ff <= 8'h00;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end else begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      if (disabled) begin
        st_ff <= ldc_idle;
        oe_ff <= 1'b0;
      end else if (start_c) begin
        st_ff <= ldc_addr;
        cnt_ff <= 4'h0;
        oe_ff <= 1'b0;
      end else if (stop_c) begin
        st_ff <= ldc_idle;
        oe_ff <= 1'b0;
      end else if (scl_rise) begin
        if (st_ff == ldc_addr || st_ff == ldc_reg || st_ff == ldc_wdata) begin
          sh_ff <= {sh_ff[6:0], sda_s};
          cnt_ff <= cnt_ff + 4'h1;
        end
      end else if (scl_fall) begin
        unique case (st_ff)
          ldc_addr: if (cnt_ff == 4'h8) begin
            if (sh_ff[7:1] == dev_addr) begin
              oe_ff <= 1'b1;
              rw_ff <= sh_ff[0];
              st_ff <= ldc_addr_ack;
            end else begin
              st_ff <= ldc_skip;
            end
          end
          // stray match: every later byte is compared too
          ldc_skip: begin
            cnt_ff <= 4'h0;
            st_ff <= ldc_addr;
          end
          ldc_addr_ack: begin
            cnt_ff <= 4'h0;
            if (rw_ff) begin
              sh_ff <= rd_data;
              rd_ff <= 1'b1;
              oe_ff <= ~rd_data[7];
              cnt_ff <= 4'h1;
              st_ff <= ldc_rdata;
            end else begin
              oe_ff <= 1'b0;
              st_ff <= ldc_reg;
            end
          end
          ldc_reg: if (cnt_ff == 4'h8) begin
            reg_ff <= sh_ff;
            oe_ff <= 1'b1;
            st_ff <= ldc_reg_ack;
          end
          ldc_reg_ack: begin
            oe_ff <= 1'b0;
            cnt_ff <= 4'h0;
            st_ff <= ldc_wdata;
          end
          ldc_wdata: if (cnt_ff == 4'h8) begin
            wd_ff <= sh_ff;
            wr_ff <= 1'b1;
            oe_ff <= 1'b1;
            st_ff <= ldc_wdata_ack;
          end
          ldc_wdata_ack: begin
            oe_ff <= 1'b0;
            st_ff <= ldc_ignore;
          end
          ldc_rdata: if (cnt_ff == 4'h8) begin
            oe_ff <= 1'b0;
            st_ff <= ldc_rdata_ack;
          end else begin
            oe_ff <= ~sh_ff[3'(7 - cnt_ff)];
            cnt_ff <= cnt_ff + 4'h1;
          end
          ldc_rdata_ack: st_ff <= ldc_ignore;
          ldc_idle, ldc_ignore: oe_ff <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: ldc_pkg.sv
// Shared constants for the four-channel LDO controller
package ldc_pkg;
  localparam int NUM_CH = 4;
  localparam int VCODE_W = 6;
  localparam int DLY_W = 3;
  localparam int MS_LEFT_W = 8;

  // Register offsets
  localparam logic [7:0] REG_VCODE_BASE = 8'h40;
  localparam logic [7:0] REG_CTRL_BASE = 8'h41;
  localparam logic [7:0] REG_CH_STRIDE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h50;

  // Control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_DLY_LSB = 4;
  localparam int CTRL_DCHG_BIT = 3;
  localparam int CTRL_LOWQ_BIT = 2;
  localparam int CTRL_UNMASK_BIT = 1;

  // Interface disable sequence
  localparam logic [7:0] SEQ_REG_KEY = 8'h0B;
  localparam logic [7:0] SEQ_REG_TWO = 8'h02;
  localparam logic [7:0] SEQ_REG_THREE = 8'h03;
  localparam logic [7:0] SEQ_KEY_SINGLE = 8'hE9;
  localparam logic [7:0] SEQ_KEY_FIRST = 8'hEE;
  localparam logic [7:0] SEQ_KEY_SECOND = 8'hEF;
  localparam logic [7:0] SEQ_VAL_TWO = 8'h07;
  localparam logic [7:0] SEQ_VAL_THREE = 8'h01;

  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DELAY_BASE_MS = 2;
  localparam int DELAY_MAX_MS = 128;

  localparam logic [7:0] RD_UNMAPPED = 8'h00;
endpackage

// File: ldc_top.sv
// LDO channel control, fault interrupt and I2C register access
`timescale 1ns/1ns
`default_nettype none
module ldc_top #(
  parameter int MS_CYCLES = ldc_pkg::MS_CYCLES,
  parameter logic [6:0] DEV_ADDR = 7'h5B, // arbitrary default
  parameter bit TWO_PASS = 1'b0,
  parameter logic [ldc_pkg::VCODE_W-1:0] VCODE_DEF_A = 6'h39,
  parameter logic [ldc_pkg::VCODE_W-1:0] VCODE_DEF_B = 6'h39,
  parameter logic [ldc_pkg::VCODE_W-1:0] VCODE_DEF_C = 6'h18,
  parameter logic [ldc_pkg::VCODE_W-1:0] VCODE_DEF_D = 6'h18,
  parameter logic [ldc_pkg::NUM_CH-1:0] EN_DEF = 4'hF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [ldc_pkg::NUM_CH-1:0] uv_below,
  output logic [ldc_pkg::VCODE_W-1:0] ldo_channel_a_vcode,
  output logic [ldc_pkg::VCODE_W-1:0] ldo_channel_b_vcode,
  output logic [ldc_pkg::VCODE_W-1:0] ldo_channel_c_vcode,
  output logic [ldc_pkg::VCODE_W-1:0] ldo_channel_d_vcode,
  output logic [ldc_pkg::NUM_CH-1:0] ldo_on,
  output logic [ldc_pkg::NUM_CH-1:0] discharge_on,
  output logic [ldc_pkg::NUM_CH-1:0] low_quiescent_on,
  output logic irq_out_n,
  output logic i2c_disabled
);
  localparam int N = ldc_pkg::NUM_CH;
  localparam int TB_W = $clog2(MS_CYCLES + 1);

  generate
    if (N != 4 || MS_CYCLES < 2) begin : g_bad
      $error("ldc_top supports four channels and MS_CYCLES >= 2");
    end
  endgenerate

  typedef enum logic [2:0] {
    ldc_s_key1, ldc_s_two1, ldc_s_three1,
    ldc_s_key2, ldc_s_two2, ldc_s_three2, ldc_s_done
  } ldc_seq_t;

  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic [N-1:0] uv_s1_ff, uv_s2_ff;
  logic [ldc_pkg::VCODE_W-1:0] vcode_ff [N];
  logic [N-1:0] en_ff, dchg_ff, lowq_ff, unmask_ff, fault_ff;
  logic [ldc_pkg::DLY_W-1:0] dly_ff [N];
  logic [N-1:0] on_ff, pend_ff, discharge_ff, lowq_out_ff;
  logic [ldc_pkg::MS_LEFT_W-1:0] left_ff [N];
  logic [TB_W-1:0] tb_ff;
  logic ms_tick_ff, irq_n_ff, off_ff, sda_out_ff, sda_oe_ff;
  ldc_seq_t seq_ff;
  logic [7:0] reg_addr, wr_data, rd_data;
  logic wr_stb, rd_stb, oe_eng;

  // Channel index of a per-channel register, or N if none
  function automatic logic [2:0] ch_of(input logic [7:0] a,
                                       input logic [7:0] base);
    logic [2:0] r;
    r = 3'(N);
    for (int i = 0; i < N; i++) begin
      if (a == 8'(base + 8'(i) * ldc_pkg::REG_CH_STRIDE)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // Millisecond count of a nonzero delay code
  function automatic logic [ldc_pkg::MS_LEFT_W-1:0] delay_ms(
      input logic [ldc_pkg::DLY_W-1:0] code);
    delay_ms = ldc_pkg::MS_LEFT_W'(ldc_pkg::DELAY_BASE_MS) << (code - 3'h1);
  endfunction

  // Expected write of each disable step
  function automatic logic [15:0] seq_expect(input ldc_seq_t s);
    logic [15:0] r;
    r = 16'h0000;
    unique case (s)
      ldc_s_key1: r = {ldc_pkg::SEQ_REG_KEY,
                       TWO_PASS ? ldc_pkg::SEQ_KEY_FIRST
                                : ldc_pkg::SEQ_KEY_SINGLE};
      ldc_s_key2: r = {ldc_pkg::SEQ_REG_KEY, ldc_pkg::SEQ_KEY_SECOND};
      ldc_s_two1, ldc_s_two2: r = {ldc_pkg::SEQ_REG_TWO,
                                   ldc_pkg::SEQ_VAL_TWO};
      ldc_s_three1, ldc_s_three2: r = {ldc_pkg::SEQ_REG_THREE,
                                       ldc_pkg::SEQ_VAL_THREE};
      ldc_s_done: r = 16'h0000;
    endcase
    return r;
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      uv_s1_ff <= '0;
      uv_s2_ff <= '0;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      uv_s1_ff <= uv_below;
      uv_s2_ff <= uv_s1_ff;
    end
  end

  ldc_i2c_slave u_i2c (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .scl_s(scl_sync_ff[1]),
    .sda_s(sda_sync_ff[1]),
    .dev_addr(DEV_ADDR),
    .disabled(off_ff),
    .rd_data(rd_data),
    .sda_oe(oe_eng),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb)
  );

  // pin driven only while engine enabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      sda_out_ff <= 1'b0;
      sda_oe_ff <= oe_eng & ~off_ff;
    end
  end
  assign sda_out = sda_out_ff;
  assign sda_oe = sda_oe_ff;

  // Register read mux
  always_comb begin
    logic [2:0] cv;
    logic [2:0] cc;
    cv = ch_of(reg_addr, ldc_pkg::REG_VCODE_BASE);
    cc = ch_of(reg_addr, ldc_pkg::REG_CTRL_BASE);
    rd_data = ldc_pkg::RD_UNMAPPED;
    if (cv != 3'(N)) begin
      rd_data = 8'(vcode_ff[cv[1:0]]);
    end else if (cc != 3'(N)) begin
      rd_data = 8'h00;
      rd_data[ldc_pkg::CTRL_EN_BIT] = en_ff[cc[1:0]];
      rd_data[ldc_pkg::CTRL_DLY_LSB +: ldc_pkg::DLY_W] = dly_ff[cc[1:0]];
      rd_data[ldc_pkg::CTRL_DCHG_BIT] = dchg_ff[cc[1:0]];
      rd_data[ldc_pkg::CTRL_LOWQ_BIT] = lowq_ff[cc[1:0]];
      rd_data[ldc_pkg::CTRL_UNMASK_BIT] = unmask_ff[cc[1:0]];
    end else if (reg_addr == ldc_pkg::REG_STATUS) begin
      // power good low while below threshold
      rd_data = 8'(~uv_s2_ff);
    end
  end

  // Millisecond timebase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_ff <= '0;
      ms_tick_ff <= 1'b0;
    end else if (tb_ff == TB_W'(MS_CYCLES - 1)) begin
      tb_ff <= '0;
      ms_tick_ff <= 1'b1;
    end else begin
      tb_ff <= tb_ff + TB_W'(1);
      ms_tick_ff <= 1'b0;
    end
  end

  generate
    for (genvar i = 0; i < N; i++) begin : g_ch
      localparam logic [ldc_pkg::VCODE_W-1:0] VDEF =
        (i == 0) ? VCODE_DEF_A : (i == 1) ? VCODE_DEF_B :
        (i == 2) ? VCODE_DEF_C : VCODE_DEF_D;
      logic wr_v, wr_c, en_rise;
      assign wr_v = wr_stb &&
        ch_of(reg_addr, ldc_pkg::REG_VCODE_BASE) == 3'(i);
      assign wr_c = wr_stb &&
        ch_of(reg_addr, ldc_pkg::REG_CTRL_BASE) == 3'(i);
      assign en_rise = wr_c & wr_data[ldc_pkg::CTRL_EN_BIT] & ~en_ff[i];

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          vcode_ff[i] <= VDEF;
        end else if (wr_v) begin
          vcode_ff[i] <= wr_data[ldc_pkg::VCODE_W-1:0];
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          en_ff[i] <= EN_DEF[i];
          dly_ff[i] <= '0;
          dchg_ff[i] <= 1'b0;
          lowq_ff[i] <= 1'b0;
          unmask_ff[i] <= 1'b0;
        end else if (wr_c) begin
          en_ff[i] <= wr_data[ldc_pkg::CTRL_EN_BIT];
          dly_ff[i] <= wr_data[ldc_pkg::CTRL_DLY_LSB +: ldc_pkg::DLY_W];
          dchg_ff[i] <= wr_data[ldc_pkg::CTRL_DCHG_BIT];
          lowq_ff[i] <= wr_data[ldc_pkg::CTRL_LOWQ_BIT];
          unmask_ff[i] <= wr_data[ldc_pkg::CTRL_UNMASK_BIT];
        end
      end

      // delay of zero or 2 ms doubling
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          on_ff[i] <= EN_DEF[i];
          pend_ff[i] <= 1'b0;
          left_ff[i] <= '0;
        end else if (wr_c && !wr_data[ldc_pkg::CTRL_EN_BIT]) begin
          on_ff[i] <= 1'b0;
          pend_ff[i] <= 1'b0;
        end else if (en_rise) begin
          if (wr_data[ldc_pkg::CTRL_DLY_LSB +: ldc_pkg::DLY_W] == '0) begin
            on_ff[i] <= 1'b1;
          end else begin
            pend_ff[i] <= 1'b1;
            left_ff[i] <= delay_ms(
              wr_data[ldc_pkg::CTRL_DLY_LSB +: ldc_pkg::DLY_W]);
          end
        end else if (pend_ff[i] && ms_tick_ff) begin
          if (left_ff[i] == ldc_pkg::MS_LEFT_W'(1)) begin
            on_ff[i] <= 1'b1;
            pend_ff[i] <= 1'b0;
          end
          left_ff[i] <= left_ff[i] - ldc_pkg::MS_LEFT_W'(1);
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          discharge_ff[i] <= 1'b0;
          lowq_out_ff[i] <= 1'b0;
        end else begin
          discharge_ff[i] <= dchg_ff[i] & ~on_ff[i];
          lowq_out_ff[i] <= lowq_ff[i];
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          fault_ff[i] <= 1'b0;
        end else if (unmask_ff[i] && uv_s2_ff[i]) begin
          fault_ff[i] <= 1'b1;
        end else if (rd_stb && reg_addr == ldc_pkg::REG_STATUS) begin
          fault_ff[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= ~|fault_ff;
    end
  end

  // stray writes only restart the match
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_ff <= ldc_s_key1;
    end else if (wr_stb && seq_ff != ldc_s_done) begin
      if ({reg_addr, wr_data} == seq_expect(seq_ff)) begin
        unique case (seq_ff)
          ldc_s_key1: seq_ff <= ldc_s_two1;
          ldc_s_two1: seq_ff <= ldc_s_three1;
          ldc_s_three1: seq_ff <= TWO_PASS ? ldc_s_key2 : ldc_s_done;
          ldc_s_key2: seq_ff <= ldc_s_two2;
          ldc_s_two2: seq_ff <= ldc_s_three2;
          ldc_s_three2: seq_ff <= ldc_s_done;
          ldc_s_done: seq_ff <= ldc_s_done;
        endcase
      end else if ({reg_addr, wr_data} == seq_expect(ldc_s_key1)) begin
        seq_ff <= ldc_s_two1;
      end else begin
        seq_ff <= ldc_s_key1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      off_ff <= 1'b0;
    end else if (seq_ff == ldc_s_done) begin
      off_ff <= 1'b1;
    end
  end

  assign ldo_channel_a_vcode = vcode_ff[0];
  assign ldo_channel_b_vcode = vcode_ff[1];
  assign ldo_channel_c_vcode = vcode_ff[2];
  assign ldo_channel_d_vcode = vcode_ff[3];
  assign ldo_on = on_ff;
  assign discharge_on = discharge_ff;
  assign low_quiescent_on = lowq_out_ff;
  assign irq_out_n = irq_n_ff;
  assign i2c_disabled = off_ff;
endmodule
`default_nettype wire

// File: ldc_top_asserts.sv
// Port-level assertions for the LDO controller
`timescale 1ns/1ns
`default_nettype none
module ldc_top_asserts #(
  parameter logic [ldc_pkg::NUM_CH-1:0] EN_DEF = 4'hF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [ldc_pkg::NUM_CH-1:0] uv_below,
  input wire logic [ldc_pkg::VCODE_W-1:0] ldo_channel_a_vcode,
  input wire logic [ldc_pkg::VCODE_W-1:0] ldo_channel_b_vcode,
  input wire logic [ldc_pkg::VCODE_W-1:0] ldo_channel_c_vcode,
  input wire logic [ldc_pkg::VCODE_W-1:0] ldo_channel_d_vcode,
  input wire logic [ldc_pkg::NUM_CH-1:0] ldo_on,
  input wire logic [ldc_pkg::NUM_CH-1:0] discharge_on,
  input wire logic [ldc_pkg::NUM_CH-1:0] low_quiescent_on,
  input wire logic irq_out_n,
  input wire logic i2c_disabled
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence fault_past;
    (|$past(uv_below, 3)) || (|$past(uv_below, 4)) || (|$past(uv_below, 5));
  endsequence
  sequence off_settled;
    i2c_disabled ##1 i2c_disabled;
  endsequence
  chk_reset_values: assert property (
    $rose(rst_n) |-> ldo_on == EN_DEF && irq_out_n && !i2c_disabled
      && discharge_on == 4'h0 && low_quiescent_on == 4'h0)
    else $error("outputs differ from reset values");
  chk_vcode_on_write: assert property (
    $changed({ldo_channel_a_vcode, ldo_channel_b_vcode, ldo_channel_c_vcode,
      ldo_channel_d_vcode}) |-> !scl_in)
    else $error("voltage code changed outside a write");
  chk_off_on_write: assert property (
    ($past(ldo_on) & ~ldo_on) != 4'h0 |-> !scl_in)
    else $error("channel turned off outside a write");
  chk_discharge_when_off: assert property (
    (discharge_on & $past(ldo_on)) == 4'h0)
    else $error("discharge on while channel enabled");
  chk_lowq_on_write: assert property (
    $changed(low_quiescent_on) |-> !scl_in)
    else $error("low quiescent changed outside a write");
  chk_irq_has_cause: assert property (
    $fell(irq_out_n) |-> fault_past)
    else $error("interrupt raised without undervoltage");
  chk_irq_release_read: assert property (
    $rose(irq_out_n) |-> !scl_in)
    else $error("interrupt released outside a read");
  chk_ack_scl_low: assert property (
    $changed(sda_oe) |-> !scl_in && !sda_out)
    else $error("data line changed while clock high");
  chk_quiet_when_off: assert property (
    off_settled |-> !sda_oe)
    else $error("data line driven after disable");
  chk_disable_sticky: assert property (
    i2c_disabled |=> i2c_disabled)
    else $error("interface re-enabled without reset");
  chk_sda_drive_low: assert property (
    !sda_out)
    else $error("data line driven high");
endmodule
bind ldc_top ldc_top_asserts #(.EN_DEF(EN_DEF)) chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .uv_below(uv_below),
  .ldo_channel_a_vcode(ldo_channel_a_vcode),
  .ldo_channel_b_vcode(ldo_channel_b_vcode),
  .ldo_channel_c_vcode(ldo_channel_c_vcode),
  .ldo_channel_d_vcode(ldo_channel_d_vcode), .ldo_on(ldo_on),
  .discharge_on(discharge_on), .low_quiescent_on(low_quiescent_on),
  .irq_out_n(irq_out_n), .i2c_disabled(i2c_disabled));
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the LDO controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int MS = 20;
  localparam logic [6:0] ADDR_A = 7'h5B; // arbitrary
  localparam logic [6:0] ADDR_B = 7'h2C; // arbitrary
  logic core_clk, rst_n, scl, m_low, oe_a, oe_b, irq_n, off_a, off_b;
  logic [3:0] uv_below, on, dchg, lowq;
  logic [5:0] va, vb, vc, vd;
  int err_total, check_count;
  wire logic sda_line;
  assign sda_line = !(m_low | oe_a | oe_b);
  ldc_top #(.MS_CYCLES(MS), .DEV_ADDR(ADDR_A)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(), .sda_oe(oe_a), .uv_below(uv_below),
    .ldo_channel_a_vcode(va), .ldo_channel_b_vcode(vb),
    .ldo_channel_c_vcode(vc), .ldo_channel_d_vcode(vd), .ldo_on(on),
    .discharge_on(dchg), .low_quiescent_on(lowq), .irq_out_n(irq_n),
    .i2c_disabled(off_a));
  ldc_top #(.MS_CYCLES(MS), .DEV_ADDR(ADDR_B), .TWO_PASS(1'b1)) dut2_u (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(), .sda_oe(oe_b), .uv_below(4'h0), .ldo_channel_a_vcode(),
    .ldo_channel_b_vcode(), .ldo_channel_c_vcode(), .ldo_channel_d_vcode(),
    .ldo_on(), .discharge_on(), .low_quiescent_on(), .irq_out_n(),
    .i2c_disabled(off_b));
  ldc_host_model #(.Q(6)) host_u (.core_clk(core_clk),
    .sda_line(sda_line), .scl(scl), .sda_low(m_low));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic t_vcode;
    logic ok, a;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      host_u.wr(ADDR_A, 8'(8'h40 + 4 * i), {2'b11, 6'(63 - i)}, ok);
      chk("wr_ack", 1'b1, ok);
    end
    chk("vcode", {6'h3F, 6'h3E, 6'h3D, 6'h3C}, {va, vb, vc, vd});
    host_u.rd(ADDR_A, 8'h44, d, ok);
    chk("rd_vcode", 8'h3E, d);
    host_u.start();
    host_u.send({ADDR_A, 1'b0}, a);
    host_u.send(8'h48, a);
    host_u.send(8'h11, a);
    host_u.send(8'h22, a);
    host_u.stop();
    chk("extra_ack", 1'b0, a);
    chk("vcode_c", 6'h11, vc);
    host_u.start();
    host_u.send({7'h11, 1'b0}, ok);
    chk("foreign_ack", 1'b0, ok);
    host_u.send({ADDR_A, 1'b0}, ok);
    host_u.stop();
    chk("stray_ack", 1'b1, ok);
  endtask
  task automatic t_delay;
    logic ok;
    int c, n;
    for (int k = 0; k < 8; k++) begin
      host_u.wr(ADDR_A, 8'h41, 8'h08, ok);
      chk("off_dchg", 2'b01, {on[0], dchg[0]});
      n = 1 << k;
      c = 0;
      fork
        host_u.wr(ADDR_A, 8'h41, 8'(8'h88 + 16 * k), ok);
        begin
          repeat (3) @(posedge oe_a);
          while (on[0] !== 1'b1 && c < 3000) begin
            @(negedge core_clk);
            c++;
          end
        end
      join
      chk("delay", 1'b1, k == 0 ? c <= 4 :
          c >= (n - 1) * MS - 2 && c <= n * MS + 3);
      repeat (2) @(posedge core_clk);
      chk("on_dchg", 2'b10, {on[0], dchg[0]});
    end
    host_u.wr(ADDR_A, 8'h41, 8'h04, ok);
    chk("lowq", 6'h01, {on[0], dchg[0], lowq});
  endtask
  task automatic t_irq;
    logic ok;
    logic [7:0] d;
    host_u.wr(ADDR_A, 8'h45, 8'h80, ok);
    uv_below <= 4'h2;
    repeat (10) @(posedge core_clk);
    chk("irq_masked", 1'b1, irq_n);
    host_u.rd(ADDR_A, 8'h50, d, ok);
    chk("pg_low", 4'hD, d[3:0]);
    host_u.wr(ADDR_A, 8'h45, 8'h82, ok);
    repeat (10) @(posedge core_clk);
    chk("irq_set", 1'b0, irq_n);
    uv_below <= 4'h0;
    repeat (10) @(posedge core_clk);
    chk("irq_held", 1'b0, irq_n);
    host_u.rd(ADDR_A, 8'h50, d, ok);
    chk("pg_ok", 4'hF, d[3:0]);
    chk("irq_clear", 1'b1, irq_n);
  endtask
  task automatic seq(input logic [6:0] dev, input logic [7:0] key,
                     input logic [7:0] v2);
    logic ok;
    host_u.wr(dev, 8'h0B, key, ok);
    host_u.wr(dev, 8'h02, v2, ok);
    host_u.wr(dev, 8'h03, 8'h01, ok);
  endtask
  task automatic t_disable;
    logic ok;
    seq(ADDR_A, 8'hE9, 8'h06);
    chk("seq_wrong", 1'b0, off_a);
    seq(ADDR_A, 8'hE9, 8'h07);
    chk("off_a", 1'b1, off_a);
    host_u.wr(ADDR_A, 8'h40, 8'h01, ok);
    chk("ack_off", 1'b0, ok);
    chk("vcode_kept", 6'h3F, va);
    seq(ADDR_B, 8'hEE, 8'h07);
    chk("off_b_half", 1'b0, off_b);
    seq(ADDR_B, 8'hEF, 8'h07);
    chk("off_b", 1'b1, off_b);
    chk("still_off", 1'b1, off_a);
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("off_rst", 1'b0, off_a);
    chk("vcode_rst2", 6'h39, va);
    host_u.wr(ADDR_A, 8'h40, 8'h01, ok);
    chk("ack_rst", 1'b1, ok);
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    uv_below = 4'h0;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("vcode_rst", {6'h39, 6'h39, 6'h18, 6'h18}, {va, vb, vc, vd});
    chk("out_rst", 14'h3C02, {on, dchg, lowq, irq_n, off_a});
    t_vcode();
    t_delay();
    t_irq();
    t_disable();
    conclude();
  end
endmodule
`default_nettype wire
